// [hw/tmcc_timer.sv]
// APB compare/capture timer: counter, four general registers, flags and pin outputs
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
`include "tmcc_regs.svh"
module tmcc_timer (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  timer_io_in,
  output logic      [3:0]  timer_io_out,
  output logic      [3:0]  timer_io_oe,
  input  wire logic        ext_count_clk,
  output logic             irq
);
  import tmcc_pkg::*;

  // Control registers written by software
  logic [1:0]  mode_r, mode_nxt;        // bit0 run, bit1 module standby
  logic [7:0]  ctrl_r, ctrl_nxt;        // clear_on_match_a, clock select, initial levels
  logic [15:0] iosel_r, iosel_nxt;      // per channel: fn[1:0], edge[3:2]
  logic [4:0]  imask_r, imask_nxt;

  // Status flags and their read arming
  logic [4:0]  stat_r, stat_nxt;        // match_capture_flag_a..d, overflow
  logic [4:0]  armed_r, armed_nxt;      // flag read while 1

  // Counter and general registers
  logic [15:0] timer_count_r, timer_count_nxt;
  logic [15:0] gr_r [4];
  logic [15:0] gr_nxt [4];

  // Pin levels and clock-source state
  logic [3:0]  pin_r, pin_nxt;
  logic [2:0]  div_r, div_nxt;
  logic        selclk_prev_r, selclk_prev_nxt;
  logic [3:0]  eq_now;                  // Channels whose count equals the register

  // Synchronised pins
  logic [3:0] io_rise, io_fall;
  logic       ext_rise, ext_fall;
  genvar g;
  for (g = 0; g < 4; g++) begin : g_sync
    tmcc_sync u_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .pin_in   (timer_io_in[g]),
      .level    (),
      .rise     (io_rise[g]),
      .fall     (io_fall[g])
    );
  end
  tmcc_sync u_sync_ext (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_in   (ext_count_clk),
    .level    (),
    .rise     (ext_rise),
    .fall     (ext_fall)
  );

  // Channel function from the io select register
  function automatic tmcc_fn_t ch_fn(input logic [15:0] sel, input int ch);
    ch_fn = tmcc_fn_t'(sel[ch*4 +: 2]);
  endfunction : ch_fn

  // Register index decode
  function automatic logic is_ofs(input logic [11:0] a, input logic [11:0] ofs);
    is_ofs = (a == ofs);
  endfunction : is_ofs

  // Bus strobes: zero wait states
  logic wr_en, rd_en, addr_ok, wr_ok;
  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= `TMCC_GEN_D_OFS);
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_ok   = wr_en & ~mode_r[`TMCC_MODE_STBY]; // Standby passes only mode writes

  // Count tick from the selected clock source
  tmcc_cks_t cks;
  logic      selclk, tick, running;
  assign cks     = tmcc_cks_t'(ctrl_r[`TMCC_CTRL_CKS_LO +: 3]);
  assign running = mode_r[`TMCC_MODE_RUN] & ~mode_r[`TMCC_MODE_STBY];
  always_comb begin
    div_nxt         = running ? div_r + 3'd1 : div_r;
    selclk          = 1'b0;
    case (cks)
      TMCC_CK_DIV1: selclk = 1'b1;
      TMCC_CK_DIV2: selclk = div_r[0];
      TMCC_CK_DIV4: selclk = div_r[1];
      TMCC_CK_DIV8: selclk = div_r[2];
      default:      selclk = 1'b0;
    endcase
    selclk_prev_nxt = selclk;
    tick            = 1'b0;
    if (running) begin
      if (cks == TMCC_CK_DIV1)
        tick = 1'b1;
      else if (!cks[2])
        tick = selclk & ~selclk_prev_r;
      else if (cks == TMCC_CK_EXT0)
        tick = ext_rise;
      else if (cks == TMCC_CK_EXT1)
        tick = ext_fall;
      else
        tick = ext_rise | ext_fall;
    end
  end

  // Capture edges per channel
  logic [3:0] cap;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      case (tmcc_edge_t'(iosel_r[i*4+2 +: 2]))
        TMCC_EDGE_RISE: cap[i] = io_rise[i];
        TMCC_EDGE_FALL: cap[i] = io_fall[i];
        TMCC_EDGE_BOTH: cap[i] = io_rise[i] | io_fall[i];
        default:        cap[i] = 1'b0;
      endcase
      if (ch_fn(iosel_r, i) != TMCC_FN_CAPTURE || mode_r[`TMCC_MODE_STBY])
        cap[i] = 1'b0;
    end
  end

  // Compare match fires on the tick that leaves the matching value
  logic [3:0] match;
  logic       clr_a;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      eq_now[i]   = (timer_count_r == gr_r[i]);
      match[i]    = eq_now[i] & tick & (ch_fn(iosel_r, i) != TMCC_FN_CAPTURE);
    end
    clr_a = match[0] & ctrl_r[`TMCC_CTRL_CLR];
  end

  logic wr_count, wr_ctrl;
  assign wr_count = wr_ok & is_ofs(paddr, `TMCC_COUNT_OFS);
  assign wr_ctrl  = wr_ok & is_ofs(paddr, `TMCC_CTRL_OFS);

  // Counter: clear beats write, write beats increment
  logic ovf;
  always_comb begin
    timer_count_nxt = timer_count_r;
    ovf             = 1'b0;
    if (clr_a)
      timer_count_nxt = 16'h0000;
    else if (wr_count)
      timer_count_nxt = pwdata[15:0];
    else if (tick) begin
      timer_count_nxt = timer_count_r + 16'h0001;
      ovf             = (timer_count_r == 16'hFFFF);
    end
  end

  // Pins: initial levels until a match changes them; a control write wins
  always_comb begin
    pin_nxt = pin_r;
    if (wr_ctrl)
      pin_nxt = pwdata[3:0];
    else
      for (int i = 0; i < 4; i++)
        if (match[i])
          case (ch_fn(iosel_r, i))
            TMCC_FN_OUT0:   pin_nxt[i] = 1'b0;
            TMCC_FN_OUT1:   pin_nxt[i] = 1'b1;
            TMCC_FN_TOGGLE: pin_nxt[i] = ~pin_r[i];
            default:        pin_nxt[i] = pin_r[i];
          endcase
  end

  // Output enables: a channel drives its pin unless it captures
  always_comb begin
    for (int i = 0; i < 4; i++)
      timer_io_oe[i] = (ch_fn(iosel_r, i) != TMCC_FN_CAPTURE);
  end
  assign timer_io_out = pin_r;

  // Control and mask registers; the mode register stays writable in standby
  always_comb begin
    mode_nxt  = mode_r;
    ctrl_nxt  = ctrl_r;
    iosel_nxt = iosel_r;
    imask_nxt = imask_r;
    if (wr_en && is_ofs(paddr, `TMCC_MODE_OFS))
      mode_nxt = pwdata[1:0];
    if (wr_ok && is_ofs(paddr, `TMCC_CTRL_OFS))
      ctrl_nxt = pwdata[7:0];
    if (wr_ok && is_ofs(paddr, `TMCC_IOSEL_OFS))
      iosel_nxt = pwdata[15:0];
    if (wr_ok && is_ofs(paddr, `TMCC_IMASK_OFS))
      imask_nxt = pwdata[4:0];
  end

  // Control register group
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_r  <= 2'b00;
      ctrl_r  <= `TMCC_CTRL_RST;
      iosel_r <= `TMCC_IOSEL_RST;
      imask_r <= 5'h00;
    end else begin
      mode_r  <= mode_nxt;
      ctrl_r  <= ctrl_nxt;
      iosel_r <= iosel_nxt;
      imask_r <= imask_nxt;
    end
  end

  // Status flags: a read arms set bits, a write of 0 clears an armed bit
  logic [4:0] ev;
  always_comb begin
    ev        = {ovf, cap | match};
    stat_nxt  = stat_r;
    armed_nxt = armed_r;
    if (rd_en && is_ofs(paddr, `TMCC_STAT_OFS))
      armed_nxt = armed_r | stat_r;
    if (wr_ok && is_ofs(paddr, `TMCC_STAT_OFS)) begin
      stat_nxt  = stat_r & ~(armed_r & ~pwdata[4:0]);
      armed_nxt = 5'h00;
    end
    stat_nxt = stat_nxt | ev;                     // Set wins over clear
  end

  // Status group
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stat_r  <= 5'h00;
      armed_r <= 5'h00;
    end else begin
      stat_r  <= stat_nxt;
      armed_r <= armed_nxt;
    end
  end

  // General registers: a capture loads the count, a software write overrides
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      gr_nxt[i] = gr_r[i];
      if (cap[i])
        gr_nxt[i] = timer_count_r;
      if (wr_ok && is_ofs(paddr, 12'(`TMCC_GEN_A_OFS + 4*i)))
        gr_nxt[i] = pwdata[15:0];
    end
  end

  // General register group
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 4; i++)
      if (rst)
        gr_r[i] <= `TMCC_GR_RST;
      else
        gr_r[i] <= gr_nxt[i];
  end

  // Counter register
  always_ff @(posedge core_clk) begin
    if (rst)
      timer_count_r <= 16'h0000;
    else
      timer_count_r <= timer_count_nxt;
  end

  // Pin level register
  always_ff @(posedge core_clk) begin
    if (rst)
      pin_r <= 4'h0;
    else
      pin_r <= pin_nxt;
  end

  // Divider and selected-clock history
  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_r         <= 3'd0;
      selclk_prev_r <= 1'b0;
    end else begin
      div_r         <= div_nxt;
      selclk_prev_r <= selclk_prev_nxt;
    end
  end

  // Interrupt stays pending in standby since flag writes are ignored there
  assign irq = |(stat_r & imask_r);

  // Read data mux
  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      `TMCC_MODE_OFS:  prdata = {30'h0, mode_r};
      `TMCC_CTRL_OFS:  prdata = {24'h0, ctrl_r};
      `TMCC_IOSEL_OFS: prdata = {16'h0, iosel_r};
      `TMCC_STAT_OFS:  prdata = {27'h0, stat_r};
      `TMCC_IMASK_OFS: prdata = {27'h0, imask_r};
      `TMCC_COUNT_OFS: prdata = {16'h0, timer_count_r};
      `TMCC_GEN_A_OFS: prdata = {16'h0, gr_r[0]};
      `TMCC_GEN_B_OFS: prdata = {16'h0, gr_r[1]};
      `TMCC_GEN_C_OFS: prdata = {16'h0, gr_r[2]};
      `TMCC_GEN_D_OFS: prdata = {16'h0, gr_r[3]};
      default:         prdata = 32'h0000_0000;
    endcase
  end
endmodule : tmcc_timer

// [hw/tmcc_regs.svh]
// Register offsets, field positions, reset values and rule summary for the compare/capture timer
// What this block does
// - With clear on match A at value N, count 0..N, period N + 1 counter clocks.
// - Output compare: flag sets to 1 when counter equals the general register.
// - Match event fires when the next counter clock moves the counter past the value.
// - Input capture: flag sets to 1 when a capture occurs.
// - A flag clears only after a read showing 1 and then a write of 0.
// - A counter clear in the write state wins and the counter write is lost.
// - A counter write coinciding with an increment stores the data; increment dropped.
// - Internal source: increment on rising edge of the selected divided clock.
// - Switching from a low to a high divided clock counts as a rising edge.
// - In module standby a pending interrupt stays asserted and cannot be cleared.
// - Initial output level bits set pin levels until the first compare match.
// - Control register write coinciding with a match wins; match output change lost.
// - Clear on match A resets the counter to zero and counting continues.
`ifndef TMCC_REGS_SVH
`define TMCC_REGS_SVH
`define TMCC_MODE_OFS    12'h000
`define TMCC_CTRL_OFS    12'h004
`define TMCC_IOSEL_OFS   12'h008
`define TMCC_STAT_OFS    12'h00C
`define TMCC_IMASK_OFS   12'h010
`define TMCC_COUNT_OFS   12'h014
`define TMCC_GEN_A_OFS   12'h018
`define TMCC_GEN_B_OFS   12'h01C
`define TMCC_GEN_C_OFS   12'h020
`define TMCC_GEN_D_OFS   12'h024
`define TMCC_GR_RST      16'hFFFF
`define TMCC_CTRL_RST    8'h00
`define TMCC_IOSEL_RST   16'h0000
`define TMCC_CTRL_CLR    7
`define TMCC_CTRL_CKS_LO 4
`define TMCC_MODE_RUN    0
`define TMCC_MODE_STBY   1
`define TMCC_STAT_OVF    4
`endif

// [hw/tmcc_pkg.sv]
// Types shared by the compare/capture timer
package tmcc_pkg;
  // Clock source selected by the control register
  typedef enum logic [2:0] {
    TMCC_CK_DIV1, TMCC_CK_DIV2, TMCC_CK_DIV4, TMCC_CK_DIV8,
    TMCC_CK_EXT0, TMCC_CK_EXT1, TMCC_CK_EXT2, TMCC_CK_EXT3
  } tmcc_cks_t;
  // Per-channel function, two bits per channel in the io select register
  typedef enum logic [1:0] {
    TMCC_FN_OUT0, TMCC_FN_OUT1, TMCC_FN_TOGGLE, TMCC_FN_CAPTURE
  } tmcc_fn_t;
  // Capture edge, two further bits per channel
  typedef enum logic [1:0] {
    TMCC_EDGE_RISE, TMCC_EDGE_FALL, TMCC_EDGE_BOTH, TMCC_EDGE_NONE
  } tmcc_edge_t;
endpackage : tmcc_pkg

// [hw/tmcc_sync.sv]
// Two-stage synchroniser with edge outputs for one timer pin
`timescale 1ns/10ps
module tmcc_sync (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic pin_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta_r, sync_r, prev_r;
  logic meta_nxt, sync_nxt, prev_nxt;

  // Next values: first stage is read only by the second
  always_comb begin
    meta_nxt = pin_in;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
  end

  // Stage registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
    end
  end

  assign level = sync_r;
  assign rise  = sync_r & ~prev_r;
  assign fall  = ~sync_r & prev_r;
endmodule : tmcc_sync

// [verification/tmcc_timer_properties.sv]
// Checker bound to the timer's ports
`timescale 1ns/10ps
`include "tmcc_regs.svh"
module tmcc_timer_properties (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  timer_io_out,
  input wire logic [3:0]  timer_io_oe,
  input wire logic        irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic       wr_acc, run_r, run_nxt, stby_r, stby_nxt;
  logic [4:0] mask_r, mask_nxt;
  assign wr_acc = psel && penable && pwrite;
  // Shadow of mode and mask as software left them
  always_comb begin
    run_nxt = run_r;
    stby_nxt = stby_r;
    mask_nxt = mask_r;
    if (wr_acc && paddr == `TMCC_MODE_OFS) begin
      run_nxt = pwdata[0];
      stby_nxt = pwdata[1];
    end
    if (wr_acc && paddr == `TMCC_IMASK_OFS && !stby_r) mask_nxt = pwdata[4:0];
  end
  always_ff @(posedge core_clk) begin
    run_r <= rst ? 1'b0 : run_nxt;
    stby_r <= rst ? 1'b0 : stby_nxt;
    mask_r <= rst ? 5'h0 : mask_nxt;
  end
  AST_CTRL_WINS: assert property (wr_acc && paddr == `TMCC_CTRL_OFS && !stby_r
    |=> timer_io_out == $past(pwdata[3:0])) else $error("pins not set by control write");
  AST_IRQ_FALL: assert property ($fell(irq) |->
    $past(wr_acc && (paddr == `TMCC_STAT_OFS || paddr == `TMCC_IMASK_OFS))
    || $past(wr_acc && (paddr == `TMCC_STAT_OFS || paddr == `TMCC_IMASK_OFS), 2))
    else $error("irq fell without a status or mask write");
  AST_STBY_HOLD: assert property (stby_r && irq && !(wr_acc && paddr == `TMCC_MODE_OFS)
    |=> irq) else $error("irq dropped in standby");
  AST_ONES_KEEP: assert property (irq && wr_acc && paddr == `TMCC_STAT_OFS
    && pwdata[4:0] == 5'h1F |=> irq) else $error("writing ones cleared a flag");
  AST_IRQ_MASKED: assert property (mask_r == 5'h0 && $past(mask_r) == 5'h0 |-> !irq)
    else $error("irq with all masked");
  AST_OE_FOLLOWS: assert property (wr_acc && paddr == `TMCC_IOSEL_OFS && !stby_r
    |=> timer_io_oe == ~{&$past(pwdata[13:12]), &$past(pwdata[9:8]),
    &$past(pwdata[5:4]), &$past(pwdata[1:0])}) else $error("oe wrong for io select");
  AST_PINS_HOLD: assert property (!run_r && !(wr_acc && paddr == `TMCC_CTRL_OFS)
    |=> $stable(timer_io_out)) else $error("pins moved while stopped");
  AST_ONE_CYCLE: assert property (psel && penable |-> pready)
    else $error("access not answered");
  cover property (stby_r && irq);
  cover property ($rose(irq));
  cover property (psel && penable && pslverr);
endmodule : tmcc_timer_properties
bind tmcc_timer tmcc_timer_properties u_tmcc_timer_properties (.core_clk, .rst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .timer_io_out,
  .timer_io_oe, .irq);

// [verification/tmcc_pin_model.sv]
// Model of the pins and the external count clock beside the timer
`timescale 1ns/10ps
module tmcc_pin_model (
  input  wire logic       core_clk,
  output logic      [3:0] pin_drv,
  output logic            ext_clk
);
  initial begin
    pin_drv = 4'h0;
    ext_clk = 1'b0;
  end
  // Pulse one line (4 is the count clock), high and low at least two clocks
  task automatic pulse(input int ch, input int width);
    int w;
    w = (width < 2) ? 2 : width;
    @(posedge core_clk);
    if (ch < 4) pin_drv[ch] <= 1'b1;
    else ext_clk <= 1'b1;
    repeat (w) @(posedge core_clk);
    if (ch < 4) pin_drv[ch] <= 1'b0;
    else ext_clk <= 1'b0;
    repeat (w) @(posedge core_clk);
  endtask : pulse
endmodule : tmcc_pin_model

// [verification/tb_tmcc_timer.sv]
// Self-checking bench for the compare/capture timer
`timescale 1ns/10ps
`include "tmcc_regs.svh"
module tb_tmcc_timer;
  logic        core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, v;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic        pready, pslverr, irq, ext_clk, err;
  logic [3:0]  io_in, io_out, io_oe, pin_drv;
  int          miscompares = 0, n_compared = 0, n;
  always #4 core_clk = ~core_clk;
  // Pin level: the timer where it drives, the model elsewhere
  assign io_in = (io_out & io_oe) | (pin_drv & ~io_oe);
  tmcc_timer u_tmcc_timer (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .timer_io_in(io_in), .timer_io_out(io_out),
    .timer_io_oe(io_oe), .ext_count_clk(ext_clk), .irq);
  tmcc_pin_model u_tmcc_pin_model (.core_clk, .pin_drv, .ext_clk);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One APB transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string what);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, e, q);
  endtask : rd
  task automatic results;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    results();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rd(`TMCC_GEN_A_OFS, 32'h0000_FFFF, "general_reg_a reset");
    rd(`TMCC_COUNT_OFS, 32'h0000_0000, "count reset");
    chk("oe reset", 32'h0000_000F, {28'h0, io_oe});
    rd(12'h100, 32'h0000_0000, "unmapped read");
    chk("slverr", 32'h0000_0001, {31'h0, err});
    wr(`TMCC_CTRL_OFS, 32'h0000_000A);
    repeat (2) @(posedge core_clk);
    chk("initial levels", 32'h0000_000A, {28'h0, io_out});
    $display("end reset test");
    // Clear on match A at three: toggle every four clocks
    wr(`TMCC_CTRL_OFS, 32'h0000_0080);
    wr(`TMCC_GEN_A_OFS, 32'h0000_0003);
    wr(`TMCC_IOSEL_OFS, 32'h0000_0002);
    wr(`TMCC_COUNT_OFS, 32'h0000_0000);
    wr(`TMCC_MODE_OFS, 32'h0000_0001);
    for (int i = 0; i < 2; i++) begin
      v = io_out[0];
      n = 0;
      while (io_out[0] === v && n < 50) begin
        @(posedge core_clk);
        n++;
      end
    end
    chk("period", 32'h0000_0004, n);
    rd(`TMCC_STAT_OFS, 32'h0000_0001, "match flag");
    wr(`TMCC_MODE_OFS, 32'h0000_0000);
    // Counter write lands on the edge where match A clears the counter
    wr(`TMCC_GEN_A_OFS, 32'h0000_0002);
    wr(`TMCC_COUNT_OFS, 32'h0000_0000);
    wr(`TMCC_MODE_OFS, 32'h0000_0001);
    wr(`TMCC_COUNT_OFS, 32'h0000_0077);
    rd(`TMCC_COUNT_OFS, 32'h0000_0002, "clear beats write");
    wr(`TMCC_MODE_OFS, 32'h0000_0000);
    $display("end period test");
    // Masking, standby and the read-then-write-zero clear
    wr(`TMCC_IMASK_OFS, 32'h0000_0000);
    repeat (2) @(posedge core_clk);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    wr(`TMCC_IMASK_OFS, 32'h0000_0001);
    repeat (2) @(posedge core_clk);
    chk("irq raised", 32'h0000_0001, {31'h0, irq});
    wr(`TMCC_STAT_OFS, 32'h0000_0001);
    wr(`TMCC_STAT_OFS, 32'h0000_0000);
    rd(`TMCC_STAT_OFS, 32'h0000_0001, "zero without read");
    wr(`TMCC_MODE_OFS, 32'h0000_0002);
    wr(`TMCC_STAT_OFS, 32'h0000_0000);
    repeat (2) @(posedge core_clk);
    chk("irq in standby", 32'h0000_0001, {31'h0, irq});
    wr(`TMCC_MODE_OFS, 32'h0000_0000);
    wr(`TMCC_STAT_OFS, 32'h0000_0001);
    rd(`TMCC_STAT_OFS, 32'h0000_0001, "one written");
    wr(`TMCC_STAT_OFS, 32'h0000_0000);
    rd(`TMCC_STAT_OFS, 32'h0000_0000, "flag cleared");
    chk("irq cleared", 32'h0000_0000, {31'h0, irq});
    wr(`TMCC_IMASK_OFS, 32'h0000_0000);
    wr(`TMCC_MODE_OFS, 32'h0000_0002);
    chk("irq off in standby", 32'h0000_0000, {31'h0, irq});
    wr(`TMCC_MODE_OFS, 32'h0000_0000);
    $display("end flag test");
    // Capture on B, rising edge, counter parked; pin states copied first
    n = io_out;
    wr(`TMCC_CTRL_OFS, n);
    wr(`TMCC_COUNT_OFS, 32'h0000_0055);
    wr(`TMCC_IOSEL_OFS, 32'h0000_0032);
    repeat (2) @(posedge core_clk);
    chk("capture oe", 32'h0000_000D, {28'h0, io_oe});
    chk("pins kept", n, {28'h0, io_out});
    u_tmcc_pin_model.pulse(1, 3);
    rd(`TMCC_GEN_B_OFS, 32'h0000_0055, "captured count");
    rd(`TMCC_STAT_OFS, 32'h0000_0002, "capture flag");
    $display("end capture test");
    // External count clock, three rising edges
    wr(`TMCC_CTRL_OFS, 32'h0000_0040);
    wr(`TMCC_COUNT_OFS, 32'h0000_0000);
    wr(`TMCC_MODE_OFS, 32'h0000_0001);
    repeat (3) u_tmcc_pin_model.pulse(4, 2);
    repeat (4) @(posedge core_clk);
    wr(`TMCC_MODE_OFS, 32'h0000_0000);
    rd(`TMCC_COUNT_OFS, 32'h0000_0003, "external count");
    $display("end external clock test");
    // Counter write while counting every clock
    wr(`TMCC_CTRL_OFS, 32'h0000_0000);
    wr(`TMCC_MODE_OFS, 32'h0000_0001);
    wr(`TMCC_COUNT_OFS, 32'h0000_0100);
    rd(`TMCC_COUNT_OFS, 32'h0000_0102, "write beats increment");
    wr(`TMCC_MODE_OFS, 32'h0000_0000);
    $display("end counter write test");
    results();
  end
endmodule : tb_tmcc_timer
